/* File: core/qcd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - count pulse only while both channels low
// - one count pulse per quadrature cycle
// - A low, B high presets direction flag
// - A high, B low clears direction flag
// - single mode: select follows direction flag
// - single and simple modes: count up or down by select at pulse
// - polarity option inverts select
// - binary or BCD counting, both directions
// - dual mode: up pulse low, flag set
// - dual mode: down pulse low, flag clear
// - option swaps up and down pulses
// - simple mode: direction on rising B only
// - simple mode: one stale count after reversal
// - simple mode: eight-bit binary value
// - direction from previous and present A/B
module qcd_decoder
(
	// system
	input  wire logic                  clk_sys,
	input  wire logic                  reset_n,
	// encoder channels, asynchronous
	input  wire logic                  chan_a,
	input  wire logic                  chan_b,
	// static configuration
	input  wire qcd_pkg::qcd_cfg_t     cfg,
	// decoded lines
	output var  qcd_pkg::qcd_pulse_t   pulses,
	output var  logic                  rotation_cw,
	// position
	output var  logic [qcd_pkg::CNT_W-1:0] position
);

	qcd_pkg::qcd_state_t st_r;
	qcd_pkg::qcd_state_t st_nxt;

	logic a_s;
	logic b_s;
	logic both_low;
	logic cnt_en;
	logic cnt_up;
	logic [qcd_pkg::CNT_W-1:0] bcd_up;
	logic [qcd_pkg::CNT_W-1:0] bcd_dn;
	logic [qcd_pkg::BCD_DIGITS:0] carry_up;
	logic [qcd_pkg::BCD_DIGITS:0] borrow_dn;

	// only the second stage is ever read
	assign a_s = st_r.sync_a[1];
	assign b_s = st_r.sync_b[1];
	assign both_low = ~a_s & ~b_s;
	// rising edge of the both-low window gives one enable per cycle
	assign cnt_en = both_low & ~st_r.prev_both_low;

	// decade counting per digit, ripple carry and borrow
	// the ripple spans four digits, short against a 50 ns period
	assign carry_up[0] = 1'b1;
	assign borrow_dn[0] = 1'b1;
	genvar gi;
	generate
		for (gi = 0; gi < qcd_pkg::BCD_DIGITS; gi++)
		begin : g_dig
			logic [3:0] d;
			assign d = st_r.count[gi*4 +: 4];
			assign carry_up[gi+1] = carry_up[gi] & (d == qcd_pkg::BCD_MAX_DIGIT);
			assign borrow_dn[gi+1] = borrow_dn[gi] & (d == qcd_pkg::BCD_MIN_DIGIT);
			assign bcd_up[gi*4 +: 4] = !carry_up[gi] ? d :
				(d == qcd_pkg::BCD_MAX_DIGIT) ? qcd_pkg::BCD_MIN_DIGIT : d + 4'h1;
			assign bcd_dn[gi*4 +: 4] = !borrow_dn[gi] ? d :
				(d == qcd_pkg::BCD_MIN_DIGIT) ? qcd_pkg::BCD_MAX_DIGIT : d - 4'h1;
		end
	endgenerate

	always_comb
	begin
		logic dir_n;
		logic pol_dir;
		logic up_p;
		logic dn_p;
		logic simple_n;
		dir_n = st_r.dir;
		pol_dir = 1'b0;
		up_p = 1'b0;
		dn_p = 1'b0;
		simple_n = st_r.simple_dir;
		st_nxt = st_r;
		st_nxt.sync_a = {st_r.sync_a[0], chan_a};
		st_nxt.sync_b = {st_r.sync_b[0], chan_b};
		st_nxt.prev_both_low = both_low;
		st_nxt.prev_b = b_s;

		// levels override any edge, as a preset and clear would
		if (!a_s && b_s)
		begin
			dir_n = 1'b1;
		end
		else if (a_s && !b_s)
		begin
			dir_n = 1'b0;
		end
		st_nxt.dir = dir_n;

		// simple variant: flop clocked by B, so it lags a reversal under B high
		if (b_s && !st_r.prev_b)
		begin
			simple_n = ~a_s;
		end
		st_nxt.simple_dir = simple_n;

		// track rotation from previous and present inverted A/B; no change and
		// a double step (both channels at once) keep the last verdict
		st_nxt.prev_ab_n = {~a_s, ~b_s};
		unique case ({st_r.prev_ab_n, ~a_s, ~b_s})
			4'h8:    st_nxt.rot_cw = 1'b1;
			4'h1:    st_nxt.rot_cw = 1'b1;
			4'h7:    st_nxt.rot_cw = 1'b1;
			4'hE:    st_nxt.rot_cw = 1'b1;
			4'h4:    st_nxt.rot_cw = 1'b0;
			4'h2:    st_nxt.rot_cw = 1'b0;
			4'hB:    st_nxt.rot_cw = 1'b0;
			4'hD:    st_nxt.rot_cw = 1'b0;
			default: st_nxt.rot_cw = st_r.rot_cw;
		endcase

		// the select follows the preset/clear flag, or the B-edge flop in the
		// simple variant; the inverted option flips the select, and the counting sense outside dual mode
		if (cfg.mode == qcd_pkg::QCD_MODE_SIMPLE)
		begin
			pol_dir = simple_n;
		end
		else
		begin
			pol_dir = dir_n;
		end
		pol_dir = pol_dir ^ cfg.polarity_inv;
		st_nxt.pulses.direction = dir_n;
		st_nxt.pulses.up_sel = pol_dir;

		// both lines idle high; the window is steered to one of them by the flag
		up_p = both_low && (dir_n ^ cfg.swap_pulses);
		dn_p = both_low && !(dir_n ^ cfg.swap_pulses);
		if (cfg.mode == qcd_pkg::QCD_MODE_DUAL)
		begin
			// no single count line in this mode, so a stray counter sees nothing
			st_nxt.pulses.count_pulse = 1'b0;
			st_nxt.pulses.up_pulse_n = !up_p;
			st_nxt.pulses.decrement_pulse_n = !dn_p;
			// the counter counts up whenever the up line pulses
			cnt_up = dir_n ^ cfg.swap_pulses;
		end
		else
		begin
			st_nxt.pulses.count_pulse = both_low;
			st_nxt.pulses.up_pulse_n = 1'b1;
			st_nxt.pulses.decrement_pulse_n = 1'b1;
			cnt_up = pol_dir;
		end

		// counter samples the select level (dual mode: flag ^ swap_pulses) at the enable; the enable lasts one
		// clock however long the both-low window stays open
		if (cnt_en)
		begin
			if (cfg.mode == qcd_pkg::QCD_MODE_SIMPLE)
			begin
				// eight-bit binary only; upper bits stay zero
				if (cnt_up)
				begin
					st_nxt.count = {{(qcd_pkg::CNT_W-qcd_pkg::SIMPLE_W){1'b0}},
						st_r.count[qcd_pkg::SIMPLE_W-1:0] + 8'h01};
				end
				else
				begin
					st_nxt.count = {{(qcd_pkg::CNT_W-qcd_pkg::SIMPLE_W){1'b0}},
						st_r.count[qcd_pkg::SIMPLE_W-1:0] - 8'h01};
				end
			end
			else if (cfg.bcd_en)
			begin
				st_nxt.count = cnt_up ? bcd_up : bcd_dn;
			end
			else
			begin
				st_nxt.count = cnt_up ? st_r.count + 16'h0001 : st_r.count - 16'h0001;
			end
		end

		// synchronous reset folded into the next state; the sync stages come out
		// at the idle level of a parked wheel, and prev_b high keeps release from
		// looking like a rising B
		if (!reset_n)
		begin
			st_nxt.sync_a = qcd_pkg::SYNC_RESET;
			st_nxt.sync_b = qcd_pkg::SYNC_RESET;
			st_nxt.prev_both_low = 1'b0;
			st_nxt.prev_b = 1'b1;
			st_nxt.dir = 1'b0;
			st_nxt.simple_dir = 1'b0;
			st_nxt.prev_ab_n = 2'h0;
			st_nxt.rot_cw = 1'b0;
			st_nxt.pulses.count_pulse = 1'b0;
			st_nxt.pulses.up_sel = 1'b0;
			st_nxt.pulses.up_pulse_n = 1'b1;
			st_nxt.pulses.decrement_pulse_n = 1'b1;
			st_nxt.pulses.direction = 1'b0;
			st_nxt.count = qcd_pkg::CNT_RESET;
		end
	end

	// one register stage for all state, every edge, no enable: pins reach the
	// outputs three edges after they change
	always_ff @(posedge clk_sys)
	begin
		st_r <= st_nxt;
	end

	assign pulses = st_r.pulses;
	assign rotation_cw = st_r.rot_cw;
	assign position = st_r.count;

endmodule

`default_nettype wire

/* File: core/qcd_pkg.sv */
package qcd_pkg;

	localparam int unsigned CNT_W = 16;
	localparam int unsigned SIMPLE_W = 8;
	localparam int unsigned BCD_DIGITS = 4;
	localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
	localparam logic [3:0] BCD_MIN_DIGIT = 4'h0;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [1:0] SYNC_RESET = 2'h3;

	typedef enum logic [1:0]
	{
		QCD_MODE_SINGLE = 2'h0,
		QCD_MODE_DUAL   = 2'h1,
		QCD_MODE_SIMPLE = 2'h3
	} qcd_mode_t;

	typedef struct packed
	{
		logic      polarity_inv;
		logic      swap_pulses;
		logic      bcd_en;
		qcd_mode_t mode;
	} qcd_cfg_t;

	typedef struct packed
	{
		logic count_pulse;
		logic up_sel;
		logic up_pulse_n;
		logic decrement_pulse_n;
		logic direction;
	} qcd_pulse_t;

	typedef struct packed
	{
		logic [1:0]       sync_a;
		logic [1:0]       sync_b;
		logic             prev_both_low;
		logic             prev_b;
		logic             dir;
		logic             simple_dir;
		logic [1:0]       prev_ab_n;
		logic             rot_cw;
		qcd_pulse_t       pulses;
		logic [CNT_W-1:0] count;
	} qcd_state_t;

endpackage

/* File: verif/qcd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module qcd_checker
(
	// watched ports
	input wire logic                clk_sys,
	input wire logic                reset_n,
	input wire logic                chan_a,
	input wire logic                chan_b,
	input wire qcd_pkg::qcd_cfg_t   cfg,
	input wire qcd_pkg::qcd_pulse_t pulses,
	input wire logic                rotation_cw,
	input wire logic [qcd_pkg::CNT_W-1:0] position
);
	// pins as the decoder sees them after its three-edge pipeline
	// one stage more holds the state before, for step direction and B edges
	logic [7:0] d_r;
	logic [1:0] g_r;
	wire lo = d_r[5:4] == 2'h0;
	wire sg = cfg.mode == qcd_pkg::QCD_MODE_SINGLE;
	wire du = cfg.mode == qcd_pkg::QCD_MODE_DUAL;
	wire dx = pulses.direction ^ cfg.swap_pulses;
	wire sm = cfg.mode == qcd_pkg::QCD_MODE_SIMPLE;
	wire [1:0] ab_prev = d_r[7:6];
	wire [1:0] ab_now = d_r[5:4];
	wire cw_step = {ab_prev, ab_now} inside {4'h1, 4'h7, 4'hE, 4'h8};
	wire ccw_step = {ab_prev, ab_now} inside {4'h4, 4'hD, 4'hB, 4'h2};
	always_ff @(posedge clk_sys)
	begin
		d_r <= {d_r[5:0], chan_a, chan_b};
		g_r <= !reset_n ? 2'h0 : g_r + {1'b0, g_r != 2'h3};
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (g_r != 2'h3);
	// a count is the rising edge of the both-low window
	sequence s_entry;
		sg && !cfg.bcd_en && $rose(pulses.count_pulse);
	endsequence
	// rising B as the decoder sees it, simple variant
	sequence s_b_rise;
		sm && ab_now[0] && !ab_prev[0];
	endsequence
	cp_low_a: assert property (!du |-> pulses.count_pulse == lo) else $error("count pulse");
	dir_set_a: assert property (d_r[5:4] == 2'h1 |-> pulses.direction) else $error("preset");
	dir_clr_a: assert property (d_r[5:4] == 2'h2 |-> !pulses.direction) else $error("clear");
	sel_pol_a: assert property (sg |-> pulses.up_sel == (pulses.direction ^ cfg.polarity_inv)) else $error("sel");
	up_line_a: assert property (pulses.up_pulse_n == !(du && lo && dx)) else $error("up line");
	dn_line_a: assert property (pulses.decrement_pulse_n == !(du && lo && !dx)) else $error("down line");
	cnt_step_a: assert property (s_entry |->
		position == $past(position) + (pulses.up_sel ? 16'h0001 : 16'hFFFF)) else $error("step");
	cnt_hold_a: assert property (sg && !$rose(pulses.count_pulse) |-> $stable(position)) else $error("hold");
	cw_step_a: assert property (cw_step |-> rotation_cw) else $error("clockwise step");
	ccw_step_a: assert property (ccw_step |-> !rotation_cw) else $error("counterclockwise step");
	b_rise_a: assert property (s_b_rise |->
		pulses.up_sel == (!ab_now[1] ^ cfg.polarity_inv)) else $error("b edge load");
	b_hold_a: assert property (sm && !(ab_now[0] && !ab_prev[0]) |->
		$stable(pulses.up_sel)) else $error("b edge hold");
	low_byte_a: assert property (sm |-> position[15:8] == 8'h00) else $error("simple width");
	bcd_digit_a: assert property (cfg.bcd_en && !sm |->
		position[3:0] <= 4'h9 && position[7:4] <= 4'h9 && position[11:8] <= 4'h9
		&& position[15:12] <= 4'h9) else $error("bcd digit");
	rst_clear_a: assert property (disable iff (1'b0) !reset_n |=>
		position == 16'h0000 && !pulses.direction && !pulses.count_pulse
		&& pulses.up_pulse_n && pulses.decrement_pulse_n) else $error("reset state");
endmodule
bind qcd_decoder qcd_checker i_qcd_checker
(
	.clk_sys     (clk_sys),
	.reset_n     (reset_n),
	.chan_a      (chan_a),
	.chan_b      (chan_b),
	.cfg         (cfg),
	.pulses      (pulses),
	.rotation_cw (rotation_cw),
	.position    (position)
);
`default_nettype wire

/* File: verif/qcd_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
module qcd_encoder
(
	// shaft motion
	input  wire logic clk_sys,
	input  wire logic fwd,
	input  wire logic bwd,
	// quadrature channels
	output var  logic chan_a,
	output var  logic chan_b
);
	// starts at 11 so leaving reset is not a step into both-low
	logic [1:0] g_r = 2'h2;
	always @(posedge clk_sys)
		g_r <= g_r + {1'b0, fwd} - {1'b0, bwd};
	assign chan_a = g_r[1]; // one channel per step, any wheel size
	assign chan_b = g_r[1] ^ g_r[0];
endmodule
`default_nettype wire

/* File: verif/qcd_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module qcd_decoder_tb;
	logic                clk_sys = 1'b0;
	logic                reset_n = 1'b0;
	logic                fwd = 1'b0;
	logic                bwd = 1'b0;
	logic                chan_a, chan_b, rotation_cw, sv;
	qcd_pkg::qcd_cfg_t   cfg = '0;
	qcd_pkg::qcd_pulse_t pulses;
	logic [15:0]         position;
	int                  errors = 0;
	int                  checks = 0;
	int                  cyc = 0;
	qcd_decoder i_qcd_decoder
	(
		.clk_sys     (clk_sys),
		.reset_n     (reset_n),
		.chan_a      (chan_a),
		.chan_b      (chan_b),
		.cfg         (cfg),
		.pulses      (pulses),
		.rotation_cw (rotation_cw),
		.position    (position)
	);
	qcd_encoder i_qcd_encoder
	(
		.clk_sys (clk_sys),
		.fwd     (fwd),
		.bwd     (bwd),
		.chan_a  (chan_a),
		.chan_b  (chan_b)
	);
	initial forever #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			errors++;
			summarize();
		end
	end
	task summarize();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	// cfg only changes inside reset so no live decode sees a half-applied mode
	task rst(input qcd_pkg::qcd_cfg_t c);
		reset_n = 1'b0;
		@(posedge clk_sys);
		#5 cfg = c;
		repeat (7) @(posedge clk_sys);
		#5 reset_n = 1'b1;
		chk(position, 16'h0000);
	endtask
	// n steps, four cycles each, then let the pipeline drain
	task mv(input int n, input logic f, input logic [15:0] e);
		repeat (n)
		begin
			fwd = f;
			bwd = !f;
			@(posedge clk_sys);
			#5 fwd = 1'b0;
			bwd = 1'b0;
			repeat (3) @(posedge clk_sys);
			#5;
		end
		repeat (4) @(posedge clk_sys);
		#5 chk(position, e);
	endtask
	task t_single();
		rst(5'h00);
		mv(8, 1'b0, 16'h0002);
		sv = rotation_cw;
		mv(8, 1'b1, 16'h0000);
		chk({15'h0, rotation_cw}, {15'h0, !sv});
		rst(5'h10);
		mv(4, 1'b0, 16'hFFFF);
	endtask
	task t_bcd();
		rst(5'h04);
		mv(4, 1'b1, 16'h9999);
		mv(4, 1'b0, 16'h0000);
	endtask
	task t_dual();
		rst(5'h01);
		mv(4, 1'b0, 16'h0001);
		mv(8, 1'b1, 16'hFFFF);
		rst(5'h09);
		mv(4, 1'b0, 16'hFFFF);
	endtask
	task t_simple();
		rst(5'h03);
		mv(4, 1'b1, 16'h00FF);
		mv(4, 1'b1, 16'h0000);
		mv(4, 1'b0, 16'h0001);
		mv(4, 1'b0, 16'h0000);
	endtask
	initial
	begin
		t_single();
		t_bcd();
		t_dual();
		t_simple();
		summarize();
	end
endmodule
`default_nettype wire
